// ---- rtl/fcmd_pkg.sv ----
// shared constants and types of the flash array command decoder
package fcmd_pkg;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hc7;
  localparam logic [7:0] OP_QUAD_MODE_ENTER = 8'h35;
  localparam logic [7:0] OP_QUAD_MODE_EXIT = 8'hf5;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 24;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam int PAGE_BYTES = 256;
  localparam int FIFO_DEPTH = 16;
  localparam int DUMMY_COUNT_LOW_BIT = 6;
  localparam int DUMMY_COUNT_HIGH_BIT = 7;
  localparam logic [3:0] DUMMY_CYC_0 = 4'h8;
  localparam logic [3:0] DUMMY_CYC_1 = 4'h6;
  localparam logic [3:0] DUMMY_CYC_2 = 4'h8;
  localparam logic [3:0] DUMMY_CYC_3 = 4'ha;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  typedef enum logic [2:0] {
    fcmd_op_none, fcmd_op_page, fcmd_op_sector, fcmd_op_half_block,
    fcmd_op_block, fcmd_op_chip, fcmd_op_quad_enter, fcmd_op_quad_exit
  } fcmd_op_t;

  typedef enum logic [2:0] {
    st_idle, st_opcode, st_addr, st_dummy, st_rdata, st_wdata, st_tail, st_standby
  } fcmd_state_t;

  function automatic logic [3:0] dummy_cycles(input logic [1:0] dc);
    case (dc)
      2'h0: dummy_cycles = DUMMY_CYC_0;
      2'h1: dummy_cycles = DUMMY_CYC_1;
      2'h2: dummy_cycles = DUMMY_CYC_2;
      default: dummy_cycles = DUMMY_CYC_3;
    endcase
  endfunction
endpackage

// ---- rtl/fcmd_fifo_if.sv ----
// valid/ready carrier between the decoder and its read-data fifo
`timescale 1ns/1ns
interface fcmd_fifo_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic clear;
  modport buffer (input in_valid, in_data, out_ready, clear, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, clear, input in_ready, out_valid, out_data);
endinterface

// ---- rtl/fcmd_fifo.sv ----
// synchronous fifo for read data on its way to the serial lines
`timescale 1ns/1ns
module fcmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // system
  input wire logic clock,
  input wire logic srst,
  // stream
  fcmd_fifo_if.buffer bf
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;
  logic push;
  logic pop;

  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_param_check
    $error("fifo depth must be a power of two");
  end

  assign empty = wr_ptr_ff == rd_ptr_ff;
  assign full = wr_ptr_ff == {~rd_ptr_ff[AW], rd_ptr_ff[AW-1:0]};
  assign bf.in_ready = !full && !bf.clear;
  assign bf.out_valid = !empty;
  assign bf.out_data = mem[rd_ptr_ff[AW-1:0]];
  assign push = bf.in_valid && bf.in_ready;
  assign pop = bf.out_ready && !empty;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= bf.in_data;
    end
  end

  // clear drops a stale prefetch when the frame ends
  always_ff @(posedge clock) begin
    if (srst || bf.clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clock) disable iff (srst)
    full && !bf.out_ready && !bf.clear |=> full && $stable(wr_ptr_ff))
    else $error("fifo pointer moved while full");
endmodule // fcmd_fifo

// ---- rtl/fcmd_decoder.sv ----
// serial flash array command decoder and bus-phase sequencer
// Functional notes
// (R01) dual io read: address, dummy and data all on two lines, single-line mode
// (R02) dual output read only in single-line mode, data on two lines until deselect
// (R03) quad output read only in single-line mode, data on four lines until deselect
// (R04) quad io read in both modes: address, dummy, data on four lines
// (R05) dummy cycle count follows configuration bits 6 and 7; host matches it
// (R06) page write in both modes, one to 256 data bytes after the address
// (R07) quad page write only in single-line mode, data on four lines
// (R08) sector wipe with three address bytes, both modes
// (R09) half block wipe with three address bytes, both modes
// (R10) block wipe with three address bytes, both modes
// (R11) host frames the quad mode exit byte on all four lines
// (R12) either chip wipe opcode, no address, wipes the array, both modes
// (R13) after quad mode exit, opcodes are taken on one line
// (R14) write, wipe and mode commands need deselect on a byte boundary, else rejected; a deselect in the address phase gives neither cmd_valid nor cmd_reject
// (R15) inputs sampled on clock rise, outputs shifted on clock fall
// (R16) unknown opcode: release outputs and wait for the next select
`timescale 1ns/1ns
module fcmd_decoder import fcmd_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // system
  input wire logic clock,
  input wire logic srst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] four_data_lines_in,
  output logic [3:0] four_data_lines_out,
  output logic [3:0] four_data_lines_oe,
  // configuration
  input wire logic [7:0] config_reg,
  // array read stream
  output logic rd_start,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [BYTE_BITS-1:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready,
  output logic rd_underrun,
  // program data
  output logic [BYTE_BITS-1:0] wr_data,
  output logic wr_valid,
  // commands
  output logic cmd_valid,
  output fcmd_op_t cmd_op,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic cmd_reject,
  output logic quad_command_mode
);
  if (DEPTH < 2) begin : g_depth_check
    $error("read fifo too shallow");
  end

  fcmd_fifo_if #(.WIDTH(BYTE_BITS)) bf ();

  fcmd_fifo #(.WIDTH(BYTE_BITS), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .bf(bf.buffer)
  );

  // pins cross into the clock domain through two flops
  logic cs_m_ff, cs_s_ff, cs_d_ff;
  logic sclk_m_ff, sclk_s_ff, sclk_d_ff;
  logic [3:0] din_m_ff, din_s_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      cs_m_ff <= 1'b1;
      cs_s_ff <= 1'b1;
      cs_d_ff <= 1'b1;
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      din_m_ff <= 4'h0;
      din_s_ff <= 4'h0;
    end else begin
      cs_m_ff <= cs_n;
      cs_s_ff <= cs_m_ff;
      cs_d_ff <= cs_s_ff;
      sclk_m_ff <= sclk;
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
      din_m_ff <= four_data_lines_in;
      din_s_ff <= din_m_ff;
    end
  end

  logic cs_high, cs_fall, sclk_rise, sclk_fall;
  assign cs_high = cs_s_ff;
  assign cs_fall = !cs_s_ff && cs_d_ff;
  assign sclk_rise = sclk_s_ff && !sclk_d_ff && !cs_high; // R15
  assign sclk_fall = !sclk_s_ff && sclk_d_ff && !cs_high; // R15

  function automatic logic is_read(input logic [7:0] op);
    is_read = op == OP_DUAL_IO_READ || op == OP_DUAL_OUTPUT_READ ||
              op == OP_QUAD_OUTPUT_READ || op == OP_QUAD_IO_READ;
  endfunction

  function automatic logic is_wipe(input logic [7:0] op);
    is_wipe = op == OP_SECTOR_WIPE || op == OP_HALF_BLOCK_WIPE || op == OP_BLOCK_WIPE;
  endfunction

  function automatic logic is_single_only(input logic [7:0] op);
    is_single_only = op == OP_DUAL_IO_READ || op == OP_DUAL_OUTPUT_READ ||
                     op == OP_QUAD_OUTPUT_READ || op == OP_QUAD_PAGE_WRITE || op == OP_QUAD_MODE_ENTER;
  endfunction

  function automatic fcmd_op_t op_kind(input logic [7:0] op);
    case (op)
      OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE: op_kind = fcmd_op_page;
      OP_SECTOR_WIPE: op_kind = fcmd_op_sector;
      OP_HALF_BLOCK_WIPE: op_kind = fcmd_op_half_block;
      OP_BLOCK_WIPE: op_kind = fcmd_op_block;
      OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: op_kind = fcmd_op_chip;
      OP_QUAD_MODE_ENTER: op_kind = fcmd_op_quad_enter;
      OP_QUAD_MODE_EXIT: op_kind = fcmd_op_quad_exit;
      default: op_kind = fcmd_op_none;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] d, input logic [2:0] n);
    case (n)
      LANES_1: shift_in = {sh[6:0], d[0]};
      LANES_2: shift_in = {sh[5:0], d[1:0]};
      default: shift_in = {sh[3:0], d};
    endcase
  endfunction

  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [2:0] n);
    lane_out = (n == LANES_2) ? {2'b00, b[7:6]} : b[7:4];
  endfunction

  fcmd_state_t state_ff;
  logic quad_ff;
  logic [7:0] op_ff;
  logic [7:0] sh_ff;
  logic [2:0] bitcnt_ff;
  logic [8:0] nbytes_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0] dummy_ff;
  logic [7:0] out_sh_ff;
  logic [2:0] out_cnt_ff;
  logic [2:0] in_lanes, out_lanes;
  logic [7:0] new_byte;
  logic byte_done, commit_ok;

  // in quad command mode every phase runs on four lines
  always_comb begin
    in_lanes = LANES_1;
    if (quad_ff) in_lanes = LANES_4;
    else if (state_ff == st_addr && op_ff == OP_DUAL_IO_READ) in_lanes = LANES_2; // R01
    else if (state_ff == st_addr && op_ff == OP_QUAD_IO_READ) in_lanes = LANES_4; // R04
    else if (state_ff == st_wdata && op_ff == OP_QUAD_PAGE_WRITE) in_lanes = LANES_4; // R07
  end
  assign out_lanes = (op_ff == OP_DUAL_IO_READ || op_ff == OP_DUAL_OUTPUT_READ) ? LANES_2 : LANES_4; // R02 R03
  assign new_byte = shift_in(sh_ff, din_s_ff, in_lanes);
  assign byte_done = sclk_rise && 3'(bitcnt_ff + in_lanes) == 3'h0;
  assign commit_ok = bitcnt_ff == 3'h0 && (state_ff == st_tail || (state_ff == st_wdata && nbytes_ff != 9'h0)); // R14

  // phase sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= st_idle;
      op_ff <= 8'h00;
      sh_ff <= 8'h00;
      bitcnt_ff <= 3'h0;
      nbytes_ff <= 9'h0;
      addr_ff <= '0;
      dummy_ff <= 4'h0;
    end else if (cs_high) begin
      state_ff <= st_idle;
      bitcnt_ff <= 3'h0;
    end else if (state_ff == st_idle) begin
      if (cs_fall) state_ff <= st_opcode; // R16
      nbytes_ff <= 9'h0;
    end else if (sclk_rise) begin
      sh_ff <= new_byte;
      bitcnt_ff <= 3'(bitcnt_ff + in_lanes); // R15
      case (state_ff)
        st_opcode: if (byte_done) begin
          op_ff <= new_byte;
          if (quad_ff ? (is_single_only(new_byte) || new_byte == OP_DUAL_OUTPUT_READ) : new_byte == OP_QUAD_MODE_EXIT)
            state_ff <= st_standby; // R02 R03 R07
          else if (is_read(new_byte) || is_wipe(new_byte) || op_kind(new_byte) == fcmd_op_page)
            state_ff <= st_addr; // R06 R08 R09 R10
          else if (op_kind(new_byte) != fcmd_op_none)
            state_ff <= st_tail; // R12 R13
          else
            state_ff <= st_standby; // R16
        end
        st_addr: if (byte_done) begin
          addr_ff <= {addr_ff[ADDR_W-9:0], new_byte};
          nbytes_ff <= 9'(nbytes_ff + 1'b1);
          if (nbytes_ff[1:0] == ADDR_BYTES - 2'h1) begin
            nbytes_ff <= 9'h0;
            if (is_read(op_ff)) begin
              state_ff <= st_dummy;
              dummy_ff <= dummy_cycles({config_reg[DUMMY_COUNT_HIGH_BIT], config_reg[DUMMY_COUNT_LOW_BIT]}); // R05
            end else if (is_wipe(op_ff)) begin
              state_ff <= st_tail; // R08 R09 R10
            end else begin
              state_ff <= st_wdata; // R06 R07
            end
          end
        end
        st_dummy: begin
          dummy_ff <= dummy_ff - 4'h1;
          if (dummy_ff == 4'h1) state_ff <= st_rdata; // R05
        end
        st_wdata: if (byte_done && nbytes_ff != 9'(PAGE_BYTES)) nbytes_ff <= 9'(nbytes_ff + 1'b1); // R06
        st_rdata, st_tail, st_standby: ;
        default: state_ff <= st_standby;
      endcase
    end
  end

  // every read, dual or quad, asks the array for data once the address is complete
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_start <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_start <= state_ff == st_addr && byte_done && nbytes_ff[1:0] == ADDR_BYTES - 2'h1 && is_read(op_ff);
      if (state_ff == st_addr && byte_done) rd_addr <= {addr_ff[ADDR_W-9:0], new_byte};
    end
  end

  // program bytes go out as they complete; page wrap is left to the array
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_valid <= state_ff == st_wdata && byte_done && !cs_high; // R06 R07
      if (state_ff == st_wdata && byte_done) wr_data <= new_byte;
    end
  end

  // commit or reject at deselect
  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_op <= fcmd_op_none;
      cmd_addr <= '0;
      quad_ff <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_reject <= 1'b0;
      if (cs_high && !cs_d_ff && (state_ff == st_tail || state_ff == st_wdata)) begin
        cmd_valid <= commit_ok; // R14
        cmd_reject <= !commit_ok; // R14
        cmd_op <= op_kind(op_ff);
        cmd_addr <= addr_ff;
        if (commit_ok && op_ff == OP_QUAD_MODE_EXIT) quad_ff <= 1'b0; // R13
        if (commit_ok && op_ff == OP_QUAD_MODE_ENTER) quad_ff <= 1'b1;
      end
    end
  end
  assign quad_command_mode = quad_ff;

  // read data leaves on the falling edge, so it stands for the host's rising edge
  logic pop;
  logic [7:0] fresh;
  assign pop = state_ff == st_rdata && sclk_fall && out_cnt_ff == 3'h0 && bf.out_valid;
  assign fresh = bf.out_valid ? bf.out_data : IDLE_BYTE;
  always_ff @(posedge clock) begin
    if (srst || cs_high || state_ff != st_rdata) begin
      four_data_lines_out <= 4'h0;
      four_data_lines_oe <= 4'h0; // R16
      out_sh_ff <= 8'h00;
      out_cnt_ff <= 3'h0;
      rd_underrun <= 1'b0;
    end else if (sclk_fall) begin
      four_data_lines_oe <= (out_lanes == LANES_2) ? OE_DUAL : OE_QUAD; // R01 R02 R03 R04
      rd_underrun <= out_cnt_ff == 3'h0 && !bf.out_valid;
      if (out_cnt_ff == 3'h0) begin
        four_data_lines_out <= lane_out(fresh, out_lanes); // R15
        out_sh_ff <= fresh << out_lanes;
        out_cnt_ff <= 3'(BYTE_BITS - 32'(out_lanes));
      end else begin
        four_data_lines_out <= lane_out(out_sh_ff, out_lanes); // R15
        out_sh_ff <= out_sh_ff << out_lanes;
        out_cnt_ff <= 3'(out_cnt_ff - out_lanes);
      end
    end
  end

  assign bf.in_valid = rd_valid;
  assign bf.in_data = rd_data;
  assign rd_ready = bf.in_ready;
  assign bf.out_ready = pop;
  assign bf.clear = cs_high;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_standby_quiet: assert property (state_ff == st_standby |-> four_data_lines_oe == 4'h0) // R16
    else $error("lines driven in standby");
  a_dual_lanes: assert property ((op_ff == OP_DUAL_OUTPUT_READ || op_ff == OP_DUAL_IO_READ) && // R02
    four_data_lines_oe != 4'h0 |-> four_data_lines_oe == OE_DUAL)
    else $error("dual read not on two lines");
  a_quad_lanes: assert property ((op_ff == OP_QUAD_OUTPUT_READ || op_ff == OP_QUAD_IO_READ) && // R03
    four_data_lines_oe != 4'h0 |-> four_data_lines_oe == OE_QUAD)
    else $error("quad read not on four lines");
  a_single_only_ops: assert property (quad_ff && state_ff == st_addr |-> // R07
    !is_single_only(op_ff) && op_ff != OP_DUAL_OUTPUT_READ)
    else $error("single-line opcode accepted in quad mode");
  a_dummy_load: assert property (state_ff == st_dummy && $past(state_ff) == st_addr |-> // R05
    dummy_ff == dummy_cycles({config_reg[DUMMY_COUNT_HIGH_BIT], config_reg[DUMMY_COUNT_LOW_BIT]}))
    else $error("dummy count does not follow configuration");
  a_exit_single: assert property (cmd_valid && cmd_op == fcmd_op_quad_exit |-> !quad_ff) // R13
    else $error("quad mode kept after exit");
  a_boundary_only: assert property (cmd_valid |-> $past(bitcnt_ff) == 3'h0 && !cmd_reject) // R14
    else $error("command committed off a byte boundary");
  a_prog_bytes: assert property (cmd_valid && cmd_op == fcmd_op_page |-> $past(nbytes_ff) != 9'h0) // R06
    else $error("page write committed without data");
  a_sample_on_rise: assert property ($changed(bitcnt_ff) && bitcnt_ff != 3'h0 |-> $past(sclk_rise)) // R15
    else $error("input bit taken off the rising edge");
  a_shift_on_fall: assert property ($changed(four_data_lines_out) && !$past(cs_high) && // R15
    $past(state_ff) == st_rdata |-> $past(sclk_fall))
    else $error("output changed off the falling edge");
endmodule // fcmd_decoder

// ---- tb/fcmd_host_model.sv ----
// serial host model driving select, clock and data lines of the decoder
`timescale 1ns/1ns
module fcmd_host_model (
  // system
  input wire logic clock,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic [3:0] drv,
  input wire logic [3:0] lines,
  input wire logic [3:0] oe
);
  logic [3:0] seen_oe;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 4'h5;
    seen_oe = 4'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one sclk period: new data while low, taken at the rise, answer read late in the high half
  task automatic cyc(input logic [3:0] d, output logic [3:0] q);
    @(negedge clock);
    sclk = 1'b0;
    drv = d;
    wait_clk(4);
    sclk = 1'b1;
    wait_clk(3);
    q = lines;
    seen_oe = seen_oe | oe;
  endtask
  // a byte msb first, msb on the highest lane; unused lanes toggle so no stale level lingers
  task automatic xfer(input logic [7:0] b_out, input int lanes, output logic [7:0] b_in);
    logic [3:0] q;
    logic [7:0] sh;
    sh = b_out;
    b_in = 8'h00;
    for (int i = 0; i < 8 / lanes; i++) begin
      case (lanes)
        1: begin
          cyc({~drv[3:1], sh[7]}, q);
          b_in = {b_in[6:0], q[1]};
        end
        2: begin
          cyc({~drv[3:2], sh[7:6]}, q);
          b_in = {b_in[5:0], q[1:0]};
        end
        default: begin
          cyc(sh[7:4], q);
          b_in = {b_in[3:0], q};
        end
      endcase
      sh = sh << lanes;
    end
  endtask
  task automatic dummy(input int n);
    logic [3:0] q;
    repeat (n) cyc(~drv, q);
  endtask
  task automatic start();
    seen_oe = 4'h0;
    cs_n = 1'b0;
    wait_clk(4);
  endtask
  // callers end on a whole byte unless they mean to break the boundary
  task automatic stop();
    wait_clk(4);
    sclk = 1'b0;
    wait_clk(4);
    cs_n = 1'b1;
    drv = ~drv;
    wait_clk(16);
  endtask
endmodule // fcmd_host_model

// ---- tb/fcmd_decoder_tb.sv ----
// self-checking bench of the flash array command decoder
`timescale 1ns/1ns
module fcmd_decoder_tb import fcmd_pkg::*;;
  localparam logic [23:0] FRAME_ADDR = 24'h3a5c71;
  logic clock, srst, cs_n, sclk, rd_start, rd_valid, rd_ready, rd_underrun, wr_valid;
  logic cmd_valid, cmd_reject, quad_command_mode;
  logic [3:0] drv, lines, dout, doe;
  logic [7:0] cfg, rd_data, wr_data;
  logic [23:0] rd_addr, cmd_addr, last_addr;
  fcmd_op_t cmd_op, last_op;
  logic [7:0] wq[$];
  int n_mismatch, comparisons, n_cmd, n_rej, n_under, n_full, rd_idx, supply;

  // each lane shows whoever drives it; the host toggles lanes it does not own
  assign lines = (dout & doe) | (drv & ~doe);

  fcmd_decoder #(.DEPTH(16)) i_dut (.clock(clock), .srst(srst), .cs_n(cs_n), .sclk(sclk),
    .four_data_lines_in(lines), .four_data_lines_out(dout), .four_data_lines_oe(doe),
    .config_reg(cfg), .rd_start(rd_start), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_underrun(rd_underrun), .wr_data(wr_data),
    .wr_valid(wr_valid), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_reject(cmd_reject), .quad_command_mode(quad_command_mode));
  fcmd_host_model i_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .drv(drv), .lines(lines), .oe(doe));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 21);
  endfunction

  // samples pre-edge values of the design outputs
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_op = cmd_op;
      last_addr = cmd_addr;
    end
    if (cmd_reject === 1'b1) n_rej++;
    if (wr_valid === 1'b1) wq.push_back(wr_data);
    if (rd_underrun === 1'b1) n_under++;
    if (rd_valid && rd_ready === 1'b0 && !cs_n) n_full++;
    if (rd_start === 1'b1) rd_idx = 0;
    else if (cs_n === 1'b1) rd_idx = 1000;
    else if (rd_valid && rd_ready === 1'b1) rd_idx++;
  end
  // array side: bytes held until taken, supply runs dry on purpose to force an underrun
  // nothing is offered from deselect until the next read start, so no stale byte is prefetched
  always @(negedge clock) begin
    rd_valid = rd_idx < supply;
    rd_data = pat(rd_idx);
  end

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // res: 0 committed, 1 rejected, 2 standby
  task automatic t_cmd(input logic [7:0] op, input int cl, input int al, input int na, input int nd,
                       input int dl, input int extra, input int res, input fcmd_op_t eop);
    logic [7:0] b;
    logic [3:0] q;
    int c0, r0;
    c0 = n_cmd;
    r0 = n_rej;
    wq.delete();
    i_host.start();
    i_host.xfer(op, cl, b);
    for (int k = 0; k < na; k++) i_host.xfer(8'(FRAME_ADDR >> (16 - 8 * k)), al, b);
    for (int k = 0; k < nd; k++) i_host.xfer(pat(k), dl, b);
    repeat (extra) i_host.cyc(4'h1, q);
    i_host.stop();
    chk(n_cmd - c0 == (res == 0) && n_rej - r0 == (res == 1), "command outcome");
    chk(i_host.seen_oe === 4'h0, "lines driven outside a read");
    if (res == 0) chk(last_op === eop && (na == 0 || last_addr === FRAME_ADDR), "command kind or address");
    if (res == 0) chk(wq.size() == nd, "program byte count");
    for (int k = 0; k < wq.size() && k < nd; k++) chk(wq[k] === pat(k), "program data");
  endtask

  task automatic t_read(input logic [7:0] op, input int cl, input int al, input int dl,
                        input logic [1:0] dc, input int nb, input int sup);
    logic [7:0] b;
    cfg = {dc, 6'h00};
    supply = sup;
    n_under = 0;
    i_host.start();
    i_host.xfer(op, cl, b);
    for (int k = 2; k >= 0; k--) i_host.xfer(8'(FRAME_ADDR >> (8 * k)), al, b);
    i_host.dummy(dc == 2'h1 ? 6 : dc == 2'h3 ? 10 : 8);
    for (int k = 0; k < nb; k++) begin
      i_host.xfer(8'h00, dl, b);
      chk(b === (k < sup ? pat(k) : 8'hff), "read data");
    end
    chk(i_host.seen_oe === (dl == 2 ? 4'h3 : 4'hf), "read lanes");
    chk(rd_addr === FRAME_ADDR, "read address");
    i_host.stop();
    chk((n_under > 0) == (nb > sup), "underrun flag");
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    srst = 1'b1;
    cfg = 8'h00;
    supply = 0;
    repeat (16) @(negedge clock);
    srst = 1'b0;
    i_host.wait_clk(8);
    chk(quad_command_mode === 1'b0 && doe === 4'h0 && cmd_valid === 1'b0, "reset state");
    t_cmd(8'h20, 1, 1, 3, 0, 1, 0, 0, fcmd_op_sector);
    t_cmd(8'h52, 1, 1, 3, 0, 1, 0, 0, fcmd_op_half_block);
    t_cmd(8'hd8, 1, 1, 3, 0, 1, 0, 0, fcmd_op_block);
    t_cmd(8'h60, 1, 1, 0, 0, 1, 0, 0, fcmd_op_chip);
    t_cmd(8'hc7, 1, 1, 0, 0, 1, 0, 0, fcmd_op_chip);
    t_cmd(8'h02, 1, 1, 3, 3, 1, 0, 0, fcmd_op_page);
    t_cmd(8'h38, 1, 1, 3, 2, 4, 0, 0, fcmd_op_page);
    t_cmd(8'h20, 1, 1, 3, 0, 1, 4, 1, fcmd_op_sector);
    t_cmd(8'h02, 1, 1, 3, 1, 1, 3, 1, fcmd_op_page);
    t_cmd(8'h00, 1, 1, 3, 0, 1, 0, 2, fcmd_op_none);
    t_cmd(8'hf5, 1, 1, 0, 0, 1, 0, 2, fcmd_op_none);
    n_full = 0;
    t_read(8'h3b, 1, 1, 2, 2'h0, 22, 20);
    chk(n_full > 0, "fifo refusal when full");
    t_read(8'h6b, 1, 1, 4, 2'h1, 4, 30);
    t_read(8'hbb, 1, 2, 2, 2'h2, 4, 30);
    t_read(8'heb, 1, 4, 4, 2'h3, 4, 30);
    t_cmd(8'h35, 1, 1, 0, 0, 1, 0, 0, fcmd_op_quad_enter);
    chk(quad_command_mode === 1'b1, "quad mode entered");
    t_cmd(8'h3b, 4, 4, 3, 0, 4, 0, 2, fcmd_op_none);
    t_cmd(8'h38, 4, 4, 3, 1, 4, 0, 2, fcmd_op_none);
    t_cmd(8'h02, 4, 4, 3, 2, 4, 0, 0, fcmd_op_page);
    t_cmd(8'hd8, 4, 4, 3, 0, 4, 0, 0, fcmd_op_block);
    t_cmd(8'h60, 4, 4, 0, 0, 4, 0, 0, fcmd_op_chip);
    t_read(8'heb, 4, 4, 4, 2'h0, 3, 30);
    t_cmd(8'hf5, 4, 4, 0, 0, 4, 0, 0, fcmd_op_quad_exit);
    chk(quad_command_mode === 1'b0, "quad mode left");
    t_cmd(8'h20, 1, 1, 3, 0, 1, 0, 0, fcmd_op_sector);
    close_out();
  end
endmodule // fcmd_decoder_tb
